// File: pkg/rcs_pkg.sv
// Constants shared by the reset configuration sequencer files.
`default_nettype none
package rcs_pkg;

    // ------------------------------------------------------------
    // Clock and delay counts
    // ------------------------------------------------------------
    localparam int unsigned INPUT_CLOCK_HZ = 20_000_000;
    localparam int unsigned POR_MIN_HOLD_CYC = 16;
    localparam int unsigned POR_RELEASE_CYC = 1024;
    localparam int unsigned PLL_LOCK_REF_CYC = 6400;
    localparam int unsigned HARD_RELEASE_CYC = 512;
    localparam int unsigned SOFT_RELEASE_CYC = 515;
    localparam int unsigned SOFT_AFTER_HARD_CYC = SOFT_RELEASE_CYC - HARD_RELEASE_CYC;
    localparam int unsigned PLL_REF_DIVIDE = 1;
    localparam int unsigned DLY_W = 16;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] REG_CFG_WORD = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ACTIVE_WORD = 8'h08;
    localparam logic [31:0] CFG_DEFAULT_WORD = 32'h0000_0000;

    // Status register fields.
    localparam int unsigned ST_STATE_LSB = 0;
    localparam int unsigned ST_HAVE_BIT = 3;
    localparam int unsigned ST_VALID_BIT = 4;
    localparam int unsigned ST_DEFAULT_BIT = 5;
    localparam int unsigned ST_LOCK_BIT = 6;
    localparam int unsigned ST_HARD_PIN_BIT = 7;
    localparam int unsigned ST_SOFT_PIN_BIT = 8;
    localparam int unsigned ST_STRAP_LSB = 16;
    localparam int unsigned STRAP_W = 14;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        RCS_EXT_POR = 3'b000,
        RCS_POR_WAIT = 3'b001,
        RCS_PLL_WAIT = 3'b010,
        RCS_HARD_WAIT = 3'b011,
        RCS_SOFT_WAIT = 3'b100,
        RCS_RUN = 3'b101
    } rcs_state_e;

endpackage : rcs_pkg
`default_nettype wire

// File: hw/rcs_delay_counter.sv
// Loadable down counter that signals when a delay has elapsed.
`timescale 1ns/1ns
`default_nettype none
module rcs_delay_counter #(
    parameter int unsigned W = 16
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Control
    input wire logic start_i,
    input wire logic tick_i,
    input wire logic [W-1:0] len_i,
    // Result
    output logic done_o
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic busy_q;
    logic busy_d;

    // done_o rises in the cycle of the last counted tick.
    assign done_o = busy_q && tick_i && (cnt_q == W'(1));

    always_comb begin
        cnt_d = cnt_q;
        busy_d = busy_q;
        if (start_i) begin
            cnt_d = len_i;
            busy_d = 1'b1;
        end else if (busy_q && tick_i) begin
            cnt_d = cnt_q - W'(1);
            if (cnt_q == W'(1)) begin
                busy_d = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
        end
    end

endmodule : rcs_delay_counter
`default_nettype wire

// File: hw/rcs_strap_capture.sv
// Holds the strap levels sampled when power-on reset is released.
`timescale 1ns/1ns
`default_nettype none
module rcs_strap_capture (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Capture strobe
    input wire logic capture_i,
    // Strap levels
    input wire logic [rcs_pkg::STRAP_W-1:0] strap_i,
    // Held straps
    output logic [rcs_pkg::STRAP_W-1:0] strap_o
);
    import rcs_pkg::*;

    logic [STRAP_W-1:0] strap_q;
    logic [STRAP_W-1:0] strap_d;

    assign strap_o = strap_q;

    // Only the release of power-on reset loads new values; rst_i clears them to zero.
    always_comb begin
        strap_d = strap_q;
        if (capture_i) begin
            strap_d = strap_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            strap_q <= '0;
        end else begin
            strap_q <= strap_d;
        end
    end

endmodule : rcs_strap_capture
`default_nettype wire

// File: hw/rcs_reset_config_sequencer.sv
// Power-on reset sequencer with strap capture and reset configuration word.
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
// How it works
// R1 - Config word via slave port or system bus.
// R2 - Straps choose system bus master or slave.
// R3 - Slave mode without word uses default word.
// R4 - Capture fourteen straps on power-on release.
// R5 - Partner holds power-on reset sixteen cycles.
// R6 - Internal power-on release 1024 cycles later.
// R7 - PLL locks after 6400 reference cycles.
// R8 - Hard reset released 512 cycles after lock.
// R9 - Soft reset released 515 cycles after lock.
// R10 - Soft reset held whenever hard reset held.
// R11 - Slave port word accepted only in power-on.
// R12 - Power-on settings kept through other resets.
// R13 - Counters advance through fixed release order.
module rcs_reset_config_sequencer #(
    parameter int unsigned PLL_LOCK_CYCLES = rcs_pkg::PLL_LOCK_REF_CYC,
    parameter int unsigned REF_DIVIDE = rcs_pkg::PLL_REF_DIVIDE
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // External power-on reset
    input wire logic power_on_reset_n_i,
    // Straps
    input wire logic reset_config_select_i,
    input wire logic config_source_select_i,
    input wire logic slave_port_sync_select_i,
    input wire logic slave_port_wide_select_i,
    input wire logic [3:0] device_select_id_i,
    input wire logic [2:0] boot_mode_sel_i,
    input wire logic watchdog_enable_strap_i,
    input wire logic [1:0] clock_mode_strap_i,
    // Direct slave port register access
    input wire logic [rcs_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // System bus configuration transfer
    input wire logic sysbus_cfg_valid_i,
    input wire logic [31:0] sysbus_cfg_word_i,
    output logic sysbus_cfg_req_o,
    // Reset outputs
    output logic int_por_n_o,
    output logic pll_lock_o,
    input wire logic hard_reset_n_i,
    output logic hard_reset_n_o,
    output logic hard_reset_oe_o,
    input wire logic soft_reset_n_i,
    output logic soft_reset_n_o,
    output logic soft_reset_oe_o,
    // Applied configuration
    output logic [31:0] cfg_word_o,
    output logic cfg_word_valid_o
);
    import rcs_pkg::*;

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    logic por_n_q;
    logic por_release;
    logic [STRAP_W-1:0] strap_in;
    logic [STRAP_W-1:0] strap_held;
    logic cfg_sysbus_sel;
    logic cfg_master_sel;

    assign por_release = power_on_reset_n_i && !por_n_q;
    assign strap_in = {reset_config_select_i, config_source_select_i, slave_port_sync_select_i,
                       slave_port_wide_select_i, device_select_id_i, boot_mode_sel_i,
                       watchdog_enable_strap_i, clock_mode_strap_i};
    assign cfg_sysbus_sel = strap_held[STRAP_W-1];
    assign cfg_master_sel = strap_held[STRAP_W-2];

    // R4 capture at release
    // R12 held across resets
    rcs_strap_capture u_straps (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .capture_i(por_release),
        .strap_i(strap_in),
        .strap_o(strap_held)
    );

    // ------------------------------------------------------------
    // Reference tick divider
    // ------------------------------------------------------------
    logic [DLY_W-1:0] div_q;
    logic [DLY_W-1:0] div_d;
    logic ref_tick;

    // The PLL reference runs at the input clock divided by REF_DIVIDE.
    assign ref_tick = (div_q == DLY_W'(REF_DIVIDE - 1));

    always_comb begin
        div_d = ref_tick ? '0 : div_q + DLY_W'(1);
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i || !power_on_reset_n_i) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    rcs_state_e state_q;
    rcs_state_e state_d;
    logic dly_start;
    logic dly_tick;
    logic dly_done;
    logic [DLY_W-1:0] dly_len;

    // One counter serves every delay, since the delays never overlap.
    always_comb begin
        state_d = state_q;
        dly_start = 1'b0;
        dly_tick = 1'b1;
        dly_len = DLY_W'(POR_RELEASE_CYC);
        // R13 strict order
        case (state_q)
            RCS_EXT_POR: begin
                // R6 start release delay
                if (por_release) begin
                    dly_start = 1'b1;
                    state_d = RCS_POR_WAIT;
                end
            end
            RCS_POR_WAIT: begin
                if (dly_done) begin
                    dly_start = 1'b1;
                    dly_len = DLY_W'(PLL_LOCK_CYCLES);
                    state_d = RCS_PLL_WAIT;
                end
            end
            RCS_PLL_WAIT: begin
                // R7 counts reference ticks
                dly_tick = ref_tick;
                if (dly_done) begin
                    dly_start = 1'b1;
                    dly_len = DLY_W'(HARD_RELEASE_CYC);
                    state_d = RCS_HARD_WAIT;
                end
            end
            RCS_HARD_WAIT: begin
                // R8 hard release count
                if (dly_done) begin
                    dly_start = 1'b1;
                    dly_len = DLY_W'(SOFT_AFTER_HARD_CYC);
                    state_d = RCS_SOFT_WAIT;
                end
            end
            RCS_SOFT_WAIT: begin
                // R9 three more cycles
                if (dly_done) begin
                    state_d = RCS_RUN;
                end
            end
            default: begin
                state_d = RCS_RUN;
            end
        endcase
        // R5 partner hold; any assertion restarts
        if (!power_on_reset_n_i) begin
            state_d = RCS_EXT_POR;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_q <= RCS_EXT_POR;
            por_n_q <= 1'b1;
        end else begin
            state_q <= state_d;
            por_n_q <= power_on_reset_n_i;
        end
    end

    rcs_delay_counter #(
        .W(DLY_W)
    ) u_delay (
        .mclk_i(mclk_i),
        .rst_i(rst_i || !power_on_reset_n_i),
        .start_i(dly_start),
        .tick_i(dly_tick),
        .len_i(dly_len),
        .done_o(dly_done)
    );

    // ------------------------------------------------------------
    // Configuration word
    // ------------------------------------------------------------
    logic in_int_por;
    logic port_wr_ok;
    logic bus_wr_ok;
    logic [31:0] cfg_word_q;
    logic [31:0] cfg_word_d;
    logic cfg_have_q;
    logic cfg_have_d;
    logic cfg_valid_q;
    logic cfg_valid_d;
    logic cfg_dflt_q;
    logic cfg_dflt_d;
    logic [31:0] active_q;
    logic [31:0] active_d;
    logic lock_event;

    assign in_int_por = (state_q == RCS_EXT_POR) || (state_q == RCS_POR_WAIT);
    assign lock_event = (state_q == RCS_PLL_WAIT) && dly_done;
    // R11 slave port only in power-on
    assign port_wr_ok = reg_wr_i && (reg_addr_i == REG_CFG_WORD) && in_int_por;
    // R1 system bus path
    assign bus_wr_ok = sysbus_cfg_valid_i && cfg_sysbus_sel
                       && ((state_q == RCS_POR_WAIT) || (state_q == RCS_PLL_WAIT));

    always_comb begin
        cfg_word_d = cfg_word_q;
        cfg_have_d = cfg_have_q;
        cfg_valid_d = cfg_valid_q;
        cfg_dflt_d = cfg_dflt_q;
        active_d = active_q;
        // A word written while power-on reset is still low survives its release only if written in its last low cycle.
        if (!power_on_reset_n_i) begin
            cfg_have_d = 1'b0;
            cfg_valid_d = 1'b0;
        end
        // R1 either path loads word
        if (port_wr_ok) begin
            cfg_word_d = reg_wdata_i;
            cfg_have_d = 1'b1;
        end else if (bus_wr_ok) begin
            cfg_word_d = sysbus_cfg_word_i;
            cfg_have_d = 1'b1;
        end
        if (lock_event) begin
            cfg_valid_d = 1'b1;
            // R3 default when none written
            if (cfg_have_q) begin
                active_d = cfg_word_q;
                cfg_dflt_d = 1'b0;
            end else begin
                active_d = CFG_DEFAULT_WORD;
                cfg_dflt_d = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cfg_word_q <= 32'h0000_0000;
            cfg_have_q <= 1'b0;
            cfg_valid_q <= 1'b0;
            cfg_dflt_q <= 1'b0;
            active_q <= 32'h0000_0000;
        end else begin
            cfg_word_q <= cfg_word_d;
            cfg_have_q <= cfg_have_d;
            cfg_valid_q <= cfg_valid_d;
            cfg_dflt_q <= cfg_dflt_d;
            active_q <= active_d;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    logic int_por_n_d;
    logic pll_lock_d;
    logic hard_n_d;
    logic soft_n_d;
    logic req_d;
    logic [31:0] rdata_d;
    logic [31:0] status;

    always_comb begin
        status = 32'h0000_0000;
        status[ST_STATE_LSB +: 3] = state_q;
        status[ST_HAVE_BIT] = cfg_have_q;
        status[ST_VALID_BIT] = cfg_valid_q;
        status[ST_DEFAULT_BIT] = cfg_dflt_q;
        status[ST_LOCK_BIT] = pll_lock_o;
        status[ST_HARD_PIN_BIT] = hard_reset_n_i;
        status[ST_SOFT_PIN_BIT] = soft_reset_n_i;
        status[ST_STRAP_LSB +: STRAP_W] = strap_held;
    end

    always_comb begin
        int_por_n_d = (state_d != RCS_EXT_POR) && (state_d != RCS_POR_WAIT);
        pll_lock_d = (state_d == RCS_HARD_WAIT) || (state_d == RCS_SOFT_WAIT) || (state_d == RCS_RUN);
        hard_n_d = (state_d == RCS_SOFT_WAIT) || (state_d == RCS_RUN);
        // R10 soft follows hard
        soft_n_d = (state_d == RCS_RUN);
        // R2 master fetches its word
        req_d = cfg_sysbus_sel && cfg_master_sel && !cfg_have_d
                && ((state_d == RCS_POR_WAIT) || (state_d == RCS_PLL_WAIT));
        rdata_d = 32'h0000_0000;
        if (reg_rd_i) begin
            if (reg_addr_i == REG_CFG_WORD) begin
                rdata_d = cfg_word_q;
            end else if (reg_addr_i == REG_STATUS) begin
                rdata_d = status;
            end else if (reg_addr_i == REG_ACTIVE_WORD) begin
                rdata_d = active_q;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            int_por_n_o <= 1'b0;
            pll_lock_o <= 1'b0;
            hard_reset_n_o <= 1'b0;
            hard_reset_oe_o <= 1'b1;
            soft_reset_n_o <= 1'b0;
            soft_reset_oe_o <= 1'b1;
            sysbus_cfg_req_o <= 1'b0;
            reg_rdata_o <= 32'h0000_0000;
            cfg_word_o <= 32'h0000_0000;
            cfg_word_valid_o <= 1'b0;
        end else begin
            int_por_n_o <= int_por_n_d;
            pll_lock_o <= pll_lock_d;
            hard_reset_n_o <= 1'b0;
            hard_reset_oe_o <= !hard_n_d;
            soft_reset_n_o <= 1'b0;
            soft_reset_oe_o <= !soft_n_d;
            sysbus_cfg_req_o <= req_d;
            reg_rdata_o <= rdata_d;
            cfg_word_o <= active_d;
            cfg_word_valid_o <= cfg_valid_d;
        end
    end

endmodule : rcs_reset_config_sequencer
`default_nettype wire

// File: verif/rcs_seq_chk.sv
// Port assertions for the reset configuration sequencer.
`timescale 1ns/1ns
`default_nettype none
module rcs_seq_chk #(
    parameter int unsigned PLL_LOCK_CYCLES = rcs_pkg::PLL_LOCK_REF_CYC,
    parameter int unsigned REF_DIVIDE = 1
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Watched ports
    input wire logic power_on_reset_n_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic int_por_n_o,
    input wire logic pll_lock_o,
    input wire logic hard_reset_oe_o,
    input wire logic soft_reset_oe_o,
    input wire logic cfg_word_valid_o
);
    localparam int LOCK_D = PLL_LOCK_CYCLES * REF_DIVIDE;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_lock_rise;
        $rose(pll_lock_o);
    endsequence
    sequence s_hard_fall;
        $fell(hard_reset_oe_o);
    endsequence
    chk_soft_covers_hard: assert property (
        hard_reset_oe_o |-> soft_reset_oe_o) else $error("soft released under hard");
    chk_por_delay: assert property (
        $rose(int_por_n_o) |-> $past(power_on_reset_n_i, 1025) && !$past(power_on_reset_n_i, 1026))
        else $error("internal release time wrong");
    chk_lock_delay: assert property (
        s_lock_rise |-> $past(int_por_n_o, LOCK_D) && !$past(int_por_n_o, LOCK_D + 1))
        else $error("lock time wrong");
    chk_hard_delay: assert property (
        s_hard_fall |-> $past(pll_lock_o, 512) && !$past(pll_lock_o, 513))
        else $error("hard release time wrong");
    chk_soft_gap: assert property (
        $fell(soft_reset_oe_o) |-> !$past(hard_reset_oe_o, 3) && $past(hard_reset_oe_o, 4))
        else $error("soft release gap wrong");
    chk_valid_at_lock: assert property (
        s_lock_rise |-> cfg_word_valid_o && !$past(cfg_word_valid_o)) else $error("word not applied at lock");
    chk_por_restart: assert property (
        !power_on_reset_n_i |=> !int_por_n_o && !pll_lock_o && hard_reset_oe_o)
        else $error("power-on did not restart");
    chk_order_hold: assert property (
        !int_por_n_o |-> !pll_lock_o && hard_reset_oe_o) else $error("release order broken");
    chk_rdata_idle: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 32'h0) else $error("read data outside slot");
endmodule : rcs_seq_chk
bind rcs_reset_config_sequencer rcs_seq_chk #(.PLL_LOCK_CYCLES(PLL_LOCK_CYCLES), .REF_DIVIDE(REF_DIVIDE)) chk_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .power_on_reset_n_i(power_on_reset_n_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .int_por_n_o(int_por_n_o), .pll_lock_o(pll_lock_o),
    .hard_reset_oe_o(hard_reset_oe_o), .soft_reset_oe_o(soft_reset_oe_o), .cfg_word_valid_o(cfg_word_valid_o));
`default_nettype wire

// File: verif/rcs_board_model.sv
// Board reset logic: power-on reset, straps and reset pull-ups.
`timescale 1ns/1ns
`default_nettype none
module rcs_board_model (
    // Clock
    input wire logic mclk_i,
    // Device reset drivers
    input wire logic hard_reset_oe_i,
    input wire logic soft_reset_oe_i,
    // Board side
    output logic power_on_reset_n_o,
    output logic [rcs_pkg::STRAP_W-1:0] strap_o,
    output wire logic hard_reset_n_o,
    output wire logic soft_reset_n_o
);
    import rcs_pkg::*;
    // Open-drain reset lines rest high on the pull-ups.
    assign hard_reset_n_o = !hard_reset_oe_i;
    assign soft_reset_n_o = !soft_reset_oe_i;
    initial begin
        power_on_reset_n_o = 1'b0;
        strap_o = '0;
    end
    task automatic power_cycle(input logic [STRAP_W-1:0] s, input int low);
        @(posedge mclk_i);
        power_on_reset_n_o <= 1'b0;
        strap_o <= s;
        repeat (low < POR_MIN_HOLD_CYC ? POR_MIN_HOLD_CYC : low) @(posedge mclk_i);
        power_on_reset_n_o <= 1'b1;
        repeat (2) @(posedge mclk_i);
        // Straps swing once the hold time is over, so a late capture shows.
        strap_o <= ~s;
    endtask : power_cycle
endmodule : rcs_board_model
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the reset configuration sequencer.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import rcs_pkg::*;
    localparam int LOCK = 20;
    logic mclk_i, rst_i, reg_wr_i, reg_rd_i, sys_vld;
    logic [7:0] reg_addr_i;
    logic [31:0] reg_wdata_i, sys_word, rdata, word;
    logic lock, int_por, req, hard_oe, soft_oe, word_vld, hard_n, soft_n;
    wire logic por_n, hard_pin, soft_pin;
    wire logic [13:0] strap;
    int fail_count = 0;
    int checks_done = 0;
    int cyc = 0;
    rcs_board_model rcs_board_model_i (.mclk_i(mclk_i), .hard_reset_oe_i(hard_oe), .soft_reset_oe_i(soft_oe),
        .power_on_reset_n_o(por_n), .strap_o(strap), .hard_reset_n_o(hard_pin), .soft_reset_n_o(soft_pin));
    rcs_reset_config_sequencer #(.PLL_LOCK_CYCLES(LOCK), .REF_DIVIDE(1)) rcs_reset_config_sequencer_i (
        .mclk_i(mclk_i), .rst_i(rst_i), .power_on_reset_n_i(por_n),
        .reset_config_select_i(strap[13]), .config_source_select_i(strap[12]),
        .slave_port_sync_select_i(strap[11]), .slave_port_wide_select_i(strap[10]),
        .device_select_id_i(strap[9:6]), .boot_mode_sel_i(strap[5:3]),
        .watchdog_enable_strap_i(strap[2]), .clock_mode_strap_i(strap[1:0]),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(rdata), .sysbus_cfg_valid_i(sys_vld), .sysbus_cfg_word_i(sys_word),
        .sysbus_cfg_req_o(req), .int_por_n_o(int_por), .pll_lock_o(lock),
        .hard_reset_n_i(hard_pin), .hard_reset_n_o(hard_n), .hard_reset_oe_o(hard_oe),
        .soft_reset_n_i(soft_pin), .soft_reset_n_o(soft_n), .soft_reset_oe_o(soft_oe),
        .cfg_word_o(word), .cfg_word_valid_o(word_vld));
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) cyc <= cyc + 1;
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        @(negedge mclk_i);
        d = rdata;
    endtask : rd
    task automatic sys(input logic [31:0] d);
        @(posedge mclk_i);
        sys_vld <= 1'b1;
        sys_word <= d;
        @(posedge mclk_i);
        sys_vld <= 1'b0;
    endtask : sys
    // Waits for the next step of the release order and returns the cycle it was seen in.
    task automatic await(input int w, output int t);
        int n;
        n = 0;
        do begin
            @(negedge mclk_i);
            n++;
        end while (!(w == 0 ? int_por === 1'b1 : w == 1 ? lock === 1'b1 :
            w == 2 ? hard_oe === 1'b0 : soft_oe === 1'b0) && n < 3000);
        if (n >= 3000) chk("step reached", 0, 1);
        t = cyc;
    endtask : await
    initial begin
        repeat (20000) @(posedge mclk_i);
        fail_count++;
        wrap_up();
    end
    initial begin
        logic [13:0] s;
        logic [31:0] w, e, st;
        int t0, t1, t2, t3, t4;
        rst_i = 1'b1;
        {reg_wr_i, reg_rd_i, sys_vld, reg_addr_i, reg_wdata_i, sys_word} = '0;
        void'($urandom(42));
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        // Run 0 writes the slave port, run 1 uses no word, run 2 is bus master.
        for (int m = 0; m < 3; m++) begin
            s = 14'($urandom);
            if (m == 1) s[13:12] = 2'b00;
            if (m == 2) s[13:12] = 2'b11;
            w = $urandom;
            e = (m == 1) ? CFG_DEFAULT_WORD : w;
            rcs_board_model_i.power_cycle(s, 16 + $urandom % 8);
            @(negedge mclk_i);
            // Release and strap sampling happened two rising edges before this point.
            t0 = cyc - 1;
            chk("reset drive", {hard_n, soft_n, hard_oe, soft_oe}, 4'b0011);
            if (m == 0) wr(REG_CFG_WORD, w);
            if (m == 0) rd(REG_CFG_WORD, st);
            if (m == 0) chk("pending word", st, w);
            if (m == 2) chk("bus request", req, 1);
            sys(w);
            await(0, t1);
            chk("release delay", t1 - t0, POR_RELEASE_CYC);
            chk("request drop", req, 0);
            wr(REG_CFG_WORD, ~e);
            await(1, t2);
            chk("lock delay", t2 - t1, LOCK);
            chk("applied word", word, e);
            chk("word valid", word_vld, 1);
            await(2, t3);
            chk("hard delay", t3 - t2, HARD_RELEASE_CYC);
            await(3, t4);
            chk("soft delay", t4 - t3, SOFT_AFTER_HARD_CYC);
            rd(REG_STATUS, st);
            chk("straps", st[29:16], s);
            chk("status", {st[8:4], st[2:0]}, {3'b111, m == 1, 1'b1, 3'b101});
            rd(REG_ACTIVE_WORD, st);
            chk("active word", st, e);
            rd(8'h0c, st);
            chk("unmapped", st, 0);
        end
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
